// *** owt_regs.vh ***
`ifndef OWT_REGS_VH
`define OWT_REGS_VH

////////////////////////////////////////////////////////////////////////////////
// Register indices; the byte address is four times the index
`define OWT_IDX_W 16
`define OWT_IDX_CTRL 16'hf020
`define OWT_IDX_PRESC 16'hf021
`define OWT_IDX_WRAP 16'hf022
`define OWT_IDX_COUNT 16'hf023
`define OWT_IDX_FIRED 16'hf024
`define OWT_IDX_IRQ_STAT 16'hf025
`define OWT_IDX_IRQ_EN 16'hf026
`define OWT_IDX_IRQ_CLR 16'hf027
`define OWT_ADDR_W 18

////////////////////////////////////////////////////////////////////////////////
// Field positions and widths
`define OWT_CTRL_RUN 0
`define OWT_CTRL_TRIG 1
`define OWT_FIRED_BIT 0
`define OWT_PRESC_W 16
`define OWT_COUNT_W 12
`define OWT_IRQ_W 3
`define OWT_EV_ZERO 0
`define OWT_EV_WRAP 1
`define OWT_EV_FIRE 2

////////////////////////////////////////////////////////////////////////////////
// Reset values
`define OWT_CTRL_RST 2'h0
`define OWT_PRESC_RST 16'h0000
`define OWT_WRAP_RST 16'hffff
`define OWT_COUNT_RST 12'hfff
`define OWT_IRQ_RST 3'h0

////////////////////////////////////////////////////////////////////////////////
// Bus responses
`define OWT_RESP_OKAY 2'h0
`define OWT_RESP_SLVERR 2'h2

`endif

// *** owt_osc_edge.v ***
`timescale 1ns/100ps

// Brings the oscillator pin into aclk and marks each rising edge.
// Limitation: the oscillator must run below half of aclk or edges are lost.
module owt_osc_edge (
    input wire aclk,
    input wire aresetn,
    input wire osc_in,
    output reg rise_pulse
);

reg meta_reg;
reg sync_reg;
reg prev_reg;

always @(posedge aclk) begin
    if (!aresetn) begin
        meta_reg <= 1'b0;
        sync_reg <= 1'b0;
        prev_reg <= 1'b0;
        rise_pulse <= 1'b0;
    end else begin
        meta_reg <= osc_in;
        sync_reg <= meta_reg;
        prev_reg <= sync_reg;
        rise_pulse <= sync_reg & ~prev_reg;
    end
end

endmodule

// *** owt_irq_bank.v ***
`timescale 1ns/100ps

// Sticky event flags with write-one-to-clear, enable mask and level output.
module owt_irq_bank #(
    parameter WIDTH = 3
) (
    input wire aclk,
    input wire aresetn,
    input wire [WIDTH-1:0] event_set,
    input wire clear_wr,
    input wire [WIDTH-1:0] clear_data,
    input wire enable_wr,
    input wire [WIDTH-1:0] enable_data,
    output reg [WIDTH-1:0] status_reg,
    output reg [WIDTH-1:0] enable_reg,
    output reg irq_reg
);

reg [WIDTH-1:0] status_next;
reg [WIDTH-1:0] enable_next;

always @* begin
    status_next = status_reg;
    enable_next = enable_reg;
    // Set beats clear so an event in the clearing cycle is kept
    if (clear_wr) begin
        status_next = status_next & ~clear_data;
    end
    status_next = status_next | event_set;
    if (enable_wr) begin
        enable_next = enable_data;
    end
end

always @(posedge aclk) begin
    if (!aresetn) begin
        status_reg <= {WIDTH{1'b0}};
        enable_reg <= {WIDTH{1'b0}};
        irq_reg <= 1'b0;
    end else begin
        status_reg <= status_next;
        enable_reg <= enable_next;
        irq_reg <= |(status_next & enable_next);
    end
end

endmodule

// *** owt_watchdog.v ***
// Operation
// - After reset counting and chip-reset triggering are both disabled.
// - Control bit 1 set lets expiry reset the chip; clear blocks it.
// - Control bit 0 set lets prescaler and down-counter run.
// - Counting without triggering is allowed for debug observation.
// - 16-bit prescaler adds one per rising edge of the oscillator input.
// - Prescaler at wrap value returns to zero and decrements down-counter.
// - Current prescaler value is readable in a read-only register.
// - Wrap field sets period: oscillator divided by wrap plus one.
// - Writing the count register loads the down-counter timeout.
// - Down-counter at zero resets chip when counting and triggering both enabled.
// - Fired status bit sets on trigger; only power-on reset clears it.
`timescale 1ns/100ps
`include "owt_regs.vh"

module owt_watchdog (
    input wire aclk,
    input wire aresetn,
    input wire por_n,
    input wire osc_input_clock,
    input wire [17:0] s_axi_awaddr,
    input wire [2:0] s_axi_awprot,
    input wire s_axi_awvalid,
    output reg s_axi_awready,
    input wire [31:0] s_axi_wdata,
    input wire [3:0] s_axi_wstrb,
    input wire s_axi_wvalid,
    output reg s_axi_wready,
    output reg [1:0] s_axi_bresp,
    output reg s_axi_bvalid,
    input wire s_axi_bready,
    input wire [17:0] s_axi_araddr,
    input wire [2:0] s_axi_arprot,
    input wire s_axi_arvalid,
    output reg s_axi_arready,
    output reg [31:0] s_axi_rdata,
    output reg [1:0] s_axi_rresp,
    output reg s_axi_rvalid,
    input wire s_axi_rready,
    output reg chip_reset_req,
    output wire irq
);

////////////////////////////////////////////////////////////////////////////////
// Byte-lane merge for partial writes
function [31:0] owt_merge;
    input [31:0] old_val;
    input [31:0] new_val;
    input [3:0] strb;
    integer i;
    begin
        owt_merge = old_val;
        for (i = 0; i < 4; i = i + 1) begin
            if (strb[i]) begin
                owt_merge[i*8 +: 8] = new_val[i*8 +: 8];
            end
        end
    end
endfunction

////////////////////////////////////////////////////////////////////////////////
// State
reg run_reg;
reg trig_reg;
reg [`OWT_PRESC_W-1:0] presc_reg;
reg [`OWT_PRESC_W-1:0] wrap_reg;
reg [`OWT_COUNT_W-1:0] count_reg;
reg fired_reg;

reg aw_held_reg;
reg w_held_reg;
reg [`OWT_IDX_W-1:0] wr_idx_reg;
reg [31:0] wdata_reg;
reg [3:0] wstrb_reg;

wire osc_rise;
wire [`OWT_IRQ_W-1:0] irq_status;
wire [`OWT_IRQ_W-1:0] irq_enable;

owt_osc_edge u_osc_edge (
    .aclk(aclk),
    .aresetn(aresetn),
    .osc_in(osc_input_clock),
    .rise_pulse(osc_rise)
);

////////////////////////////////////////////////////////////////////////////////
// Write channel: address and data may arrive in either order
wire aw_hs = s_axi_awvalid & s_axi_awready;
wire w_hs = s_axi_wvalid & s_axi_wready;
wire do_write = aw_held_reg & w_held_reg & ~s_axi_bvalid;
wire wr_ctrl = do_write & (wr_idx_reg == `OWT_IDX_CTRL);
wire wr_wrap = do_write & (wr_idx_reg == `OWT_IDX_WRAP);
wire wr_count = do_write & (wr_idx_reg == `OWT_IDX_COUNT);
wire wr_irq_en = do_write & (wr_idx_reg == `OWT_IDX_IRQ_EN);
wire wr_irq_clr = do_write & (wr_idx_reg == `OWT_IDX_IRQ_CLR);
reg wr_mapped;

always @* begin
    case (wr_idx_reg)
        `OWT_IDX_CTRL, `OWT_IDX_PRESC, `OWT_IDX_WRAP, `OWT_IDX_COUNT,
        `OWT_IDX_FIRED, `OWT_IDX_IRQ_STAT, `OWT_IDX_IRQ_EN,
        `OWT_IDX_IRQ_CLR: wr_mapped = 1'b1;
        default: wr_mapped = 1'b0;
    endcase
end

wire aw_held_next = do_write ? 1'b0 : (aw_hs | aw_held_reg);
wire w_held_next = do_write ? 1'b0 : (w_hs | w_held_reg);
wire bvalid_next = do_write | (s_axi_bvalid & ~s_axi_bready);

always @(posedge aclk) begin
    if (!aresetn) begin
        aw_held_reg <= 1'b0;
        w_held_reg <= 1'b0;
        wr_idx_reg <= {`OWT_IDX_W{1'b0}};
        wdata_reg <= 32'h00000000;
        wstrb_reg <= 4'h0;
        s_axi_awready <= 1'b0;
        s_axi_wready <= 1'b0;
        s_axi_bvalid <= 1'b0;
        s_axi_bresp <= `OWT_RESP_OKAY;
    end else begin
        if (aw_hs) begin
            wr_idx_reg <= s_axi_awaddr[17:2];
        end
        if (w_hs) begin
            wdata_reg <= s_axi_wdata;
            wstrb_reg <= s_axi_wstrb;
        end
        aw_held_reg <= aw_held_next;
        w_held_reg <= w_held_next;
        s_axi_bvalid <= bvalid_next;
        // Ready drops while a beat is parked so nothing is overwritten
        s_axi_awready <= ~aw_held_next & ~bvalid_next;
        s_axi_wready <= ~w_held_next & ~bvalid_next;
        if (do_write) begin
            s_axi_bresp <= wr_mapped ? `OWT_RESP_OKAY : `OWT_RESP_SLVERR;
        end
    end
end

////////////////////////////////////////////////////////////////////////////////
// Read channel
wire ar_hs = s_axi_arvalid & s_axi_arready;
wire [`OWT_IDX_W-1:0] rd_idx = s_axi_araddr[17:2];
reg [31:0] rd_data;
reg [1:0] rd_resp;

always @* begin
    rd_data = 32'h00000000;
    rd_resp = `OWT_RESP_OKAY;
    case (rd_idx)
        `OWT_IDX_CTRL: begin
            rd_data[`OWT_CTRL_RUN] = run_reg;
            rd_data[`OWT_CTRL_TRIG] = trig_reg;
        end
        `OWT_IDX_PRESC: rd_data[`OWT_PRESC_W-1:0] = presc_reg;
        `OWT_IDX_WRAP: rd_data[`OWT_PRESC_W-1:0] = wrap_reg;
        `OWT_IDX_COUNT: rd_data[`OWT_COUNT_W-1:0] = count_reg;
        `OWT_IDX_FIRED: rd_data[`OWT_FIRED_BIT] = fired_reg;
        `OWT_IDX_IRQ_STAT: rd_data[`OWT_IRQ_W-1:0] = irq_status;
        `OWT_IDX_IRQ_EN: rd_data[`OWT_IRQ_W-1:0] = irq_enable;
        `OWT_IDX_IRQ_CLR: rd_data = 32'h00000000;
        default: rd_resp = `OWT_RESP_SLVERR;
    endcase
end

always @(posedge aclk) begin
    if (!aresetn) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid <= 1'b0;
        s_axi_rdata <= 32'h00000000;
        s_axi_rresp <= `OWT_RESP_OKAY;
    end else begin
        if (ar_hs) begin
            s_axi_rvalid <= 1'b1;
            s_axi_arready <= 1'b0;
            s_axi_rdata <= rd_data;
            s_axi_rresp <= rd_resp;
        end else if (s_axi_rvalid & s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
            s_axi_arready <= 1'b1;
        end else if (!s_axi_rvalid) begin
            s_axi_arready <= 1'b1;
        end
    end
end

////////////////////////////////////////////////////////////////////////////////
// Control and wrap registers
wire [31:0] ctrl_merged = owt_merge({30'h00000000, trig_reg, run_reg}, wdata_reg, wstrb_reg);
wire [31:0] wrap_merged = owt_merge({16'h0000, wrap_reg}, wdata_reg, wstrb_reg);
wire [31:0] count_merged = owt_merge({20'h00000, count_reg}, wdata_reg, wstrb_reg);
wire [1:0] ctrl_rst = `OWT_CTRL_RST;

always @(posedge aclk) begin
    if (!aresetn) begin
        run_reg <= ctrl_rst[`OWT_CTRL_RUN];
        trig_reg <= ctrl_rst[`OWT_CTRL_TRIG];
        wrap_reg <= `OWT_WRAP_RST;
    end else begin
        if (wr_ctrl) begin
            run_reg <= ctrl_merged[`OWT_CTRL_RUN];
            trig_reg <= ctrl_merged[`OWT_CTRL_TRIG];
        end
        if (wr_wrap) begin
            wrap_reg <= wrap_merged[`OWT_PRESC_W-1:0];
        end
    end
end

////////////////////////////////////////////////////////////////////////////////
// Prescaler and down-counter
wire presc_step = run_reg & osc_rise;
wire presc_wrap = presc_step & (presc_reg == wrap_reg);
wire count_zero = (count_reg == {`OWT_COUNT_W{1'b0}});
wire count_dec = presc_wrap & ~count_zero;
// A reload in the same cycle overrides the tick, so no zero event is raised then
wire reach_zero = count_dec & ~wr_count & (count_reg == {{(`OWT_COUNT_W-1){1'b0}}, 1'b1});
// Expiry needs both run and trigger; count-only mode never fires
wire fire = run_reg & trig_reg & count_zero & ~chip_reset_req;

always @(posedge aclk) begin
    if (!aresetn) begin
        presc_reg <= `OWT_PRESC_RST;
        count_reg <= `OWT_COUNT_RST;
    end else begin
        if (presc_wrap) begin
            presc_reg <= {`OWT_PRESC_W{1'b0}};
        end else if (presc_step) begin
            presc_reg <= presc_reg + {{(`OWT_PRESC_W-1){1'b0}}, 1'b1};
        end
        // A reload in the same cycle as a tick wins; the kick is never lost
        if (wr_count) begin
            count_reg <= count_merged[`OWT_COUNT_W-1:0];
        end else if (count_dec) begin
            count_reg <= count_reg - {{(`OWT_COUNT_W-1){1'b0}}, 1'b1};
        end
    end
end

////////////////////////////////////////////////////////////////////////////////
// Chip reset request and fired flag
// The request holds until the chip reset comes back through aresetn
always @(posedge aclk) begin
    if (!aresetn) begin
        chip_reset_req <= 1'b0;
    end else if (fire) begin
        chip_reset_req <= 1'b1;
    end
end

// Only power-on reset clears this, so it survives the reset it caused
always @(posedge aclk) begin
    if (!por_n) begin
        fired_reg <= 1'b0;
    end else if (fire) begin
        fired_reg <= 1'b1;
    end
end

////////////////////////////////////////////////////////////////////////////////
// Interrupt events
wire [`OWT_IRQ_W-1:0] irq_events;
assign irq_events[`OWT_EV_ZERO] = reach_zero;
assign irq_events[`OWT_EV_WRAP] = presc_wrap;
assign irq_events[`OWT_EV_FIRE] = fire;

owt_irq_bank #(
    .WIDTH(`OWT_IRQ_W)
) u_irq_bank (
    .aclk(aclk),
    .aresetn(aresetn),
    .event_set(irq_events),
    .clear_wr(wr_irq_clr),
    .clear_data(wdata_reg[`OWT_IRQ_W-1:0]),
    .enable_wr(wr_irq_en),
    .enable_data(wdata_reg[`OWT_IRQ_W-1:0]),
    .status_reg(irq_status),
    .enable_reg(irq_enable),
    .irq_reg(irq)
);

endmodule

// *** owt_watchdog_assertions.sv ***
`timescale 1ns/100ps
module owt_watchdog_assertions (
    input wire aclk,
    input wire aresetn,
    input wire s_axi_awvalid,
    input wire s_axi_awready,
    input wire s_axi_wvalid,
    input wire s_axi_wready,
    input wire [1:0] s_axi_bresp,
    input wire s_axi_bvalid,
    input wire s_axi_bready,
    input wire s_axi_arvalid,
    input wire s_axi_arready,
    input wire [31:0] s_axi_rdata,
    input wire s_axi_rvalid,
    input wire s_axi_rready,
    input wire chip_reset_req
);
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    bvalid_holds_a: assert property (s_axi_bvalid && !s_axi_bready |=>
        s_axi_bvalid && $stable(s_axi_bresp)) else $error("bvalid dropped early");
    rvalid_holds_a: assert property (s_axi_rvalid && !s_axi_rready |=>
        s_axi_rvalid && $stable(s_axi_rdata)) else $error("rvalid dropped early");
    write_answer_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
        && s_axi_wready |-> ##2 s_axi_bvalid) else $error("no write answer");
    read_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("no read answer");
    aw_busy_a: assert property (s_axi_awvalid && s_axi_awready |=> !s_axi_awready [*2])
        else $error("awready back too soon");
    ar_busy_a: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("arready during read answer");
    reset_quiet_a: assert property ($rose(aresetn) |->
        !chip_reset_req && !s_axi_bvalid && !s_axi_rvalid)
        else $error("outputs not quiet after reset");
    reset_req_sticky_a: assert property (chip_reset_req |=> chip_reset_req)
        else $error("chip reset request dropped");
endmodule

bind owt_watchdog owt_watchdog_assertions i_chk (
    .aclk(aclk),
    .aresetn(aresetn),
    .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready),
    .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready),
    .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata),
    .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready),
    .chip_reset_req(chip_reset_req)
);

// *** oscillator_watchdog_timer_tb_top.sv ***
`timescale 1ns/100ps
`include "owt_regs.vh"
module oscillator_watchdog_timer_tb_top;
    reg aclk = 0, aresetn = 0, por_n = 0, osc_input_clock = 0;
    reg [17:0] awaddr = 0, araddr = 0;
    reg [31:0] wdata = 0;
    reg [3:0] wstrb = 4'hf;
    reg awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
    wire awready, wready, bvalid, arready, rvalid, chip_reset_req, irq;
    wire [1:0] bresp, rresp;
    wire [31:0] rdata;
    int miscompares = 0, tests_run = 0, p = 0, w = 0, c = 0, k, i;
    always #10 aclk = ~aclk;
    owt_watchdog i_dut (.aclk(aclk), .aresetn(aresetn), .por_n(por_n),
        .osc_input_clock(osc_input_clock), .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
        .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arprot(3'h0), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
        .s_axi_rvalid(rvalid), .s_axi_rready(rready), .chip_reset_req(chip_reset_req),
        .irq(irq));
    ////////////////////////////////////////////////////////////////////////////
    task chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            miscompares++;
            $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // Waits on the answer with no cycle limit; only the watchdog ends a hang
    task wr(input [15:0] idx, input [31:0] d, input [1:0] er);
        bit done;
        done = 1'b0;
        @(posedge aclk);
        awaddr <= {idx, 2'b00};
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        while (!done) begin
            @(posedge aclk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
            if (bvalid) begin
                bready <= 1'b0;
                done = 1'b1;
                chk(bresp, er);
            end
        end
    endtask
    task rd_chk(input [15:0] idx, input [31:0] e, input [1:0] er);
        bit done;
        done = 1'b0;
        @(posedge aclk);
        araddr <= {idx, 2'b00};
        arvalid <= 1'b1;
        rready <= 1'b1;
        while (!done) begin
            @(posedge aclk);
            if (arready) arvalid <= 1'b0;
            if (rvalid) begin
                rready <= 1'b0;
                done = 1'b1;
                chk(rdata, e);
                chk(rresp, er);
            end
        end
    endtask
    // Pin edges are spaced 8 cycles apart so the synchroniser never drops one
    task osc(input int n);
        repeat (n) begin
            repeat (4) @(posedge aclk);
            osc_input_clock <= 1;
            repeat (4) @(posedge aclk);
            osc_input_clock <= 0;
        end
        repeat (8) @(posedge aclk);
    endtask
    task step;
        if (p == w) begin
            p = 0;
            c = (c > 0) ? c - 1 : 0;
        end else p++;
    endtask
    task tally_and_finish;
        $display("miscompares=%0d tests_run=%0d", miscompares, tests_run);
        if (miscompares == 0 && tests_run > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    // The pin is read after the wait, not when the task is called
    task pin(input bit sel_rst, input logic e);
        repeat (2) @(posedge aclk);
        chk(sel_rst ? chip_reset_req : irq, e);
    endtask
    ////////////////////////////////////////////////////////////////////////////
    initial begin
        #400000;
        miscompares++;
        tally_and_finish;
    end
    initial begin
        void'($urandom(32'h7956));
        repeat (10) @(posedge aclk);
        aresetn <= 1'b1;
        por_n <= 1'b1;
        rd_chk(`OWT_IDX_CTRL, 32'h0, 2'h0);
        rd_chk(`OWT_IDX_PRESC, 32'h0, 2'h0);
        rd_chk(`OWT_IDX_WRAP, 32'hffff, 2'h0);
        rd_chk(`OWT_IDX_COUNT, 32'hfff, 2'h0);
        rd_chk(`OWT_IDX_FIRED, 32'h0, 2'h0);
        rd_chk(16'h0100, 32'h0, 2'h2);
        wr(16'h0100, 32'h1, 2'h2);
        wr(`OWT_IDX_PRESC, 32'h5, 2'h0);
        // Only the low byte lane is written; the upper wrap byte keeps its value
        wstrb <= 4'h1;
        wr(`OWT_IDX_WRAP, 32'h12345678, 2'h0);
        wstrb <= 4'hf;
        rd_chk(`OWT_IDX_WRAP, 32'hff78, 2'h0);
        osc(3);
        rd_chk(`OWT_IDX_PRESC, 32'h0, 2'h0);
        rd_chk(`OWT_IDX_COUNT, 32'hfff, 2'h0);
        for (i = 0; i < 4; i++) begin
            w = p + $urandom_range(0, 3);
            c = $urandom_range(1, 4);
            k = $urandom_range(1, 12);
            wr(`OWT_IDX_WRAP, w, 2'h0);
            wr(`OWT_IDX_COUNT, c, 2'h0);
            rd_chk(`OWT_IDX_COUNT, c, 2'h0);
            wr(`OWT_IDX_CTRL, 32'h1, 2'h0);
            repeat (k) step;
            osc(k);
            rd_chk(`OWT_IDX_PRESC, p, 2'h0);
            rd_chk(`OWT_IDX_COUNT, c, 2'h0);
            rd_chk(`OWT_IDX_FIRED, 32'h0, 2'h0);
            chk(chip_reset_req, 1'b0);
        end
        // Wrap at the current prescaler value so the very next edge decrements
        w = p;
        wr(`OWT_IDX_IRQ_CLR, 32'h7, 2'h0);
        wr(`OWT_IDX_WRAP, w, 2'h0);
        wr(`OWT_IDX_COUNT, 32'h1, 2'h0);
        wr(`OWT_IDX_IRQ_EN, 32'h1, 2'h0);
        osc(1);
        rd_chk(`OWT_IDX_IRQ_STAT, 32'h3, 2'h0);
        pin(1'b0, 1'b1);
        wr(`OWT_IDX_IRQ_EN, 32'h0, 2'h0);
        pin(1'b0, 1'b0);
        wr(`OWT_IDX_IRQ_EN, 32'h1, 2'h0);
        wr(`OWT_IDX_IRQ_CLR, 32'h1, 2'h0);
        pin(1'b0, 1'b0);
        wr(`OWT_IDX_IRQ_EN, 32'h4, 2'h0);
        wr(`OWT_IDX_COUNT, 32'h2, 2'h0);
        wr(`OWT_IDX_WRAP, 32'h0, 2'h0);
        wr(`OWT_IDX_CTRL, 32'h3, 2'h0);
        osc(1);
        chk(chip_reset_req, 1'b0);
        osc(1);
        chk(chip_reset_req, 1'b1);
        rd_chk(`OWT_IDX_FIRED, 32'h1, 2'h0);
        pin(1'b0, 1'b1);
        aresetn <= 1'b0;
        repeat (3) @(posedge aclk);
        aresetn <= 1'b1;
        pin(1'b1, 1'b0);
        rd_chk(`OWT_IDX_CTRL, 32'h0, 2'h0);
        rd_chk(`OWT_IDX_FIRED, 32'h1, 2'h0);
        por_n <= 1'b0;
        repeat (2) @(posedge aclk);
        por_n <= 1'b1;
        rd_chk(`OWT_IDX_FIRED, 32'h0, 2'h0);
        tally_and_finish;
    end
endmodule
